/* File: rtl/gpc_pkg.sv */
`default_nettype none
package gpc_pkg;
    // ****************************************
    // geometry
    // ****************************************
    localparam int NUM_PORTS   = 13;
    localparam int PORT_W      = 8;
    localparam int NUM_PINS    = NUM_PORTS * PORT_W;
    localparam int ADDR_W      = 12;
    localparam int SYNC_STAGES = 2;

    // ****************************************
    // register map, byte offsets inside one port window
    // ****************************************
    localparam int          PORT_LSB        = 6;     // 0x40 bytes per port
    localparam logic [3:0]  PORT_IDX_MAX    = 4'hc;
    localparam logic [5:0]  OFS_DATA_OUT    = 6'h00;
    localparam logic [5:0]  OFS_PIN_STATE   = 6'h04;
    localparam logic [5:0]  OFS_DRIVE_MODE  = 6'h08;
    localparam logic [5:0]  OFS_PIN_CONFIG  = 6'h0c;
    localparam logic [5:0]  OFS_SOURCE_SEL  = 6'h10;
    localparam logic [5:0]  OFS_INT_MASK    = 6'h14;
    localparam logic [5:0]  OFS_INT_STATUS  = 6'h18;

    // pin config word fields, one bit per pin in each byte
    localparam int CFG_LVTTL_LSB   = 0;
    localparam int CFG_IN_DIS_LSB  = 8;
    localparam int CFG_OUT_DIS_LSB = 16;
    localparam int CFG_SLOW_LSB    = 24;
    localparam int DRIVE_FIELD_W   = 4;
    localparam int SRC_FIELD_W     = 2;

    // reset values
    localparam logic [7:0]  RST_DATA_OUT   = 8'h00;
    localparam logic [31:0] RST_DRIVE_MODE = 32'h0000_0000;
    localparam logic [31:0] RST_PIN_CONFIG = 32'h0000_0000;
    localparam logic [15:0] RST_SOURCE_SEL = 16'h0000;
    localparam logic [7:0]  RST_INT_MASK   = 8'h00;
    localparam logic [7:0]  RST_INT_STATUS = 8'h00;

    // pins that own a fixed-function peripheral slot
    localparam logic [NUM_PINS-1:0] FIXED_PIN_MAP = {NUM_PINS{1'b1}};

    // ****************************************
    // encodings
    // ****************************************
    typedef enum logic [3:0] {
        DRV_DISABLED    = 4'h0,
        DRV_STRONG      = 4'h1,
        DRV_RES_UP      = 4'h2,
        DRV_RES_DOWN    = 4'h3,
        DRV_WEAK_UP     = 4'h4,
        DRV_WEAK_DOWN   = 4'h5,
        DRV_OPEN_DRAIN  = 4'h6,
        DRV_OPEN_SOURCE = 4'h7,
        DRV_INPUT_ONLY  = 4'h8
    } gpc_drive_e;

    typedef enum logic [1:0] {
        SRC_DATA_REG = 2'h0,
        SRC_FIXED    = 2'h1,
        SRC_FABRIC   = 2'h2
    } gpc_source_e;
endpackage
`default_nettype wire

/* File: rtl/gpc_port_ctrl.sv */
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module gpc_port_ctrl
    import gpc_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [NUM_PINS-1:0]  pad_in,
    output logic      [NUM_PINS-1:0]  pad_out,
    output logic      [NUM_PINS-1:0]  pad_oe_n,
    output logic      [NUM_PINS-1:0]  pad_pull_up,
    output logic      [NUM_PINS-1:0]  pad_pull_down,
    output logic      [NUM_PINS-1:0]  pad_weak,
    output logic      [NUM_PINS-1:0]  pad_in_en,
    output logic      [NUM_PINS-1:0]  pad_lvttl,
    output logic      [NUM_PINS-1:0]  pad_slow,
    input  wire logic [NUM_PINS-1:0]  fixed_fn_out,
    input  wire logic [NUM_PINS-1:0]  fabric_out,
    output logic      [NUM_PINS-1:0]  pin_to_fabric,
    input  wire logic                 hold_req,
    output logic      [NUM_PORTS-1:0] port_irq,
    output logic                      irq
);
    // ****************************************
    // state
    // ****************************************
    logic [NUM_PORTS-1:0][7:0]  data_out_ff;
    logic [NUM_PORTS-1:0][31:0] drive_ff;
    logic [NUM_PORTS-1:0][31:0] config_ff;
    logic [NUM_PORTS-1:0][15:0] source_ff;
    logic [NUM_PORTS-1:0][7:0]  mask_ff;
    logic [NUM_PORTS-1:0][7:0]  status_ff;
    logic [NUM_PORTS-1:0][7:0]  pin_state_ff;
    logic [31:0]                prdata_ff;
    logic                       pready_ff;
    logic                       pslverr_ff;
    logic [NUM_PORTS-1:0]       port_irq_ff;
    logic                       irq_ff;
    logic [NUM_PINS-1:0]        pad_out_ff;
    logic [NUM_PINS-1:0]        pad_oe_n_ff;
    logic [NUM_PINS-1:0]        pad_pull_up_ff;
    logic [NUM_PINS-1:0]        pad_pull_down_ff;
    logic [NUM_PINS-1:0]        pad_weak_ff;
    logic [NUM_PINS-1:0]        pad_in_en_ff;
    logic [NUM_PINS-1:0]        pad_lvttl_ff;
    logic [NUM_PINS-1:0]        pad_slow_ff;

    // ****************************************
    // combinational nets
    // ****************************************
    logic [NUM_PINS-1:0]        pin_sync;
    logic [NUM_PINS-1:0]        in_gate;
    logic [NUM_PINS-1:0]        in_eff;
    logic [NUM_PINS-1:0]        pin_event;
    logic [NUM_PINS-1:0]        nxt_out;
    logic [NUM_PINS-1:0]        nxt_oe_n;
    logic [NUM_PINS-1:0]        nxt_up;
    logic [NUM_PINS-1:0]        nxt_down;
    logic [NUM_PINS-1:0]        nxt_weak;
    logic [NUM_PINS-1:0]        nxt_lvttl;
    logic [NUM_PINS-1:0]        nxt_slow;
    logic [NUM_PINS-1:0]        state_flat;
    logic [NUM_PINS-1:0]        mask_flat;
    logic [3:0]                 acc_port;
    logic [5:0]                 acc_ofs;
    logic                       port_hit;
    logic                       wr_take;
    logic [31:0]                nxt_prdata;
    logic                       nxt_slverr;

    // ****************************************
    // apb slave: one-cycle answer, data latched in setup
    // ****************************************
    assign acc_port = paddr[PORT_LSB +: 4];
    assign acc_ofs  = {paddr[5:2], 2'b00};
    assign port_hit = (paddr[ADDR_W-1:PORT_LSB+4] == '0) && (acc_port <= PORT_IDX_MAX);
    assign wr_take  = psel && penable && pready_ff && pwrite && !pslverr_ff;

    // read mux and decode, sampled in the setup cycle
    always_comb
    begin
        nxt_prdata = 32'h0000_0000;
        nxt_slverr = 1'b0;
        if (!port_hit)
            nxt_slverr = 1'b1;
        else if (acc_ofs == OFS_DATA_OUT)
            nxt_prdata = {24'h00_0000, data_out_ff[acc_port]};
        else if (acc_ofs == OFS_PIN_STATE)
            nxt_prdata = {24'h00_0000, pin_state_ff[acc_port]};
        else if (acc_ofs == OFS_DRIVE_MODE)
            nxt_prdata = drive_ff[acc_port];
        else if (acc_ofs == OFS_PIN_CONFIG)
            nxt_prdata = config_ff[acc_port];
        else if (acc_ofs == OFS_SOURCE_SEL)
            nxt_prdata = {16'h0000, source_ff[acc_port]};
        else if (acc_ofs == OFS_INT_MASK)
            nxt_prdata = {24'h00_0000, mask_ff[acc_port]};
        else if (acc_ofs == OFS_INT_STATUS)
            nxt_prdata = {24'h00_0000, status_ff[acc_port]};
        else
            nxt_slverr = 1'b1;
    end

    // bus answer flops; pready rises only in the access cycle
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            pready_ff <= psel && !penable;
            if (psel && !penable)
            begin
                prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_prdata;
                pslverr_ff <= nxt_slverr;
            end
        end
    end

    // ****************************************
    // input path
    // ****************************************
    gpc_sync
    #(
        .WIDTH    (NUM_PINS)
    )
    u_pin_sync
    (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in (pad_in),
        .sync_out (pin_sync)
    );

    assign state_flat = pin_state_ff;
    assign mask_flat  = mask_ff;
    assign in_eff     = pin_sync & in_gate;
    assign pin_event  = in_eff ^ state_flat;     // both edges count as events

    // pin state follows the gated synchronised level
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            pin_state_ff <= '0;
        else
            pin_state_ff <= in_eff;
    end

    // ****************************************
    // per-port registers and interrupt status
    // ****************************************
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++)
        begin : g_port
            logic [7:0] clr_bits;
            logic [7:0] set_bits;
            logic       wr_here;

            assign wr_here  = wr_take && (acc_port == 4'(gp));
            assign clr_bits = (wr_here && acc_ofs == OFS_INT_STATUS) ? pwdata[7:0] : 8'h00;
            assign set_bits = pin_event[gp*PORT_W +: PORT_W] & mask_ff[gp];

            // software-owned configuration
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    data_out_ff[gp] <= RST_DATA_OUT;
                    drive_ff[gp]    <= RST_DRIVE_MODE;
                    config_ff[gp]   <= RST_PIN_CONFIG;
                    source_ff[gp]   <= RST_SOURCE_SEL;
                    mask_ff[gp]     <= RST_INT_MASK;
                end
                else if (wr_here)
                begin
                    if (acc_ofs == OFS_DATA_OUT)
                        data_out_ff[gp] <= pwdata[7:0];
                    else if (acc_ofs == OFS_DRIVE_MODE)
                        drive_ff[gp] <= pwdata;
                    else if (acc_ofs == OFS_PIN_CONFIG)
                        config_ff[gp] <= pwdata;
                    else if (acc_ofs == OFS_SOURCE_SEL)
                        source_ff[gp] <= pwdata[15:0];
                    else if (acc_ofs == OFS_INT_MASK)
                        mask_ff[gp] <= pwdata[7:0];
                end
            end

            // sticky status: a new event beats a same-cycle clear
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                    status_ff[gp] <= RST_INT_STATUS;
                else
                    status_ff[gp] <= (status_ff[gp] & ~clr_bits) | set_bits;
            end
        end
    endgenerate

    // one request per port plus a combined line
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            port_irq_ff <= '0;
            irq_ff      <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < NUM_PORTS; i++)
                port_irq_ff[i] <= |(status_ff[i] & mask_ff[i]);
            irq_ff <= |(status_ff & mask_ff);
        end
    end

    // ****************************************
    // per-pin output mux and driver decode
    // ****************************************
    genvar gb;
    generate
        for (gb = 0; gb < NUM_PINS; gb++)
        begin : g_pin
            localparam int PRT = gb / PORT_W;
            localparam int BIT = gb % PORT_W;
            gpc_drive_e  mode;
            gpc_source_e src;
            logic        val;
            logic        drive;
            logic        out_dis;

            assign mode    = gpc_drive_e'(drive_ff[PRT][BIT*DRIVE_FIELD_W +: DRIVE_FIELD_W]);
            assign src     = gpc_source_e'(source_ff[PRT][BIT*SRC_FIELD_W +: SRC_FIELD_W]);
            assign out_dis = config_ff[PRT][CFG_OUT_DIS_LSB + BIT];
            assign in_gate[gb] = (mode != DRV_DISABLED) && !config_ff[PRT][CFG_IN_DIS_LSB + BIT];
            assign nxt_lvttl[gb] = config_ff[PRT][CFG_LVTTL_LSB + BIT];
            assign nxt_slow[gb]  = config_ff[PRT][CFG_SLOW_LSB + BIT];

            // fixed functions bypass the fabric and only reach mapped pins
            always_comb
            begin
                val = data_out_ff[PRT][BIT];
                if (src == SRC_FIXED && FIXED_PIN_MAP[gb])
                    val = fixed_fn_out[gb];
                else if (src == SRC_FABRIC)
                    val = fabric_out[gb];
            end

            // resistive modes drive the active level and pull the other
            always_comb
            begin
                drive         = 1'b0;
                nxt_up[gb]    = 1'b0;
                nxt_down[gb]  = 1'b0;
                nxt_weak[gb]  = 1'b0;
                case (mode)
                    DRV_STRONG:      drive = 1'b1;
                    DRV_RES_UP:      begin drive = !val; nxt_up[gb] = 1'b1; end
                    DRV_RES_DOWN:    begin drive = val; nxt_down[gb] = 1'b1; end
                    DRV_WEAK_UP:     begin drive = !val; nxt_up[gb] = 1'b1; nxt_weak[gb] = 1'b1; end
                    DRV_WEAK_DOWN:   begin drive = val; nxt_down[gb] = 1'b1; nxt_weak[gb] = 1'b1; end
                    DRV_OPEN_DRAIN:  drive = !val;
                    DRV_OPEN_SOURCE: drive = val;
                    default:         drive = 1'b0;
                endcase
                nxt_out[gb]  = val;
                nxt_oe_n[gb] = !(drive && !out_dis);
            end
        end
    endgenerate

    // pad flops; hold freezes them so sleep keeps the last state
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pad_out_ff       <= '0;
            pad_oe_n_ff      <= '1;
            pad_pull_up_ff   <= '0;
            pad_pull_down_ff <= '0;
            pad_weak_ff      <= '0;
            pad_in_en_ff     <= '0;
            pad_lvttl_ff     <= '0;
            pad_slow_ff      <= '0;
        end
        else if (!hold_req)
        begin
            pad_out_ff       <= nxt_out;
            pad_oe_n_ff      <= nxt_oe_n;
            pad_pull_up_ff   <= nxt_up;
            pad_pull_down_ff <= nxt_down;
            pad_weak_ff      <= nxt_weak;
            pad_in_en_ff     <= in_gate;
            pad_lvttl_ff     <= nxt_lvttl;
            pad_slow_ff      <= nxt_slow;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prdata        = prdata_ff;
    assign pready        = pready_ff;
    assign pslverr       = pslverr_ff;
    assign pad_out       = pad_out_ff;
    assign pad_oe_n      = pad_oe_n_ff;
    assign pad_pull_up   = pad_pull_up_ff;
    assign pad_pull_down = pad_pull_down_ff;
    assign pad_weak      = pad_weak_ff;
    assign pad_in_en     = pad_in_en_ff;
    assign pad_lvttl     = pad_lvttl_ff;
    assign pad_slow      = pad_slow_ff;
    assign pin_to_fabric = pin_state_ff;
    assign port_irq      = port_irq_ff;
    assign irq           = irq_ff;

    // ****************************************
    // assertions on pin 0 of port 0, plus reset and hold checks on all pins
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    logic p0_strong;
    assign p0_strong = (drive_ff[0][3:0] == DRV_STRONG) && !config_ff[0][CFG_OUT_DIS_LSB] && !hold_req;

    AST_RESET_DISABLED: assert property ($rose(reset_n) |-> (&pad_oe_n) && (pad_in_en == '0))
        else $error("pins not disabled after reset");
    AST_OUT_DISABLE: assert property (!hold_req && config_ff[0][CFG_OUT_DIS_LSB] |=> pad_oe_n[0])
        else $error("output disable ignored");
    AST_IN_DISABLE: assert property (!hold_req && config_ff[0][CFG_IN_DIS_LSB] |=> !pad_in_en[0])
        else $error("input disable ignored");
    AST_HOLD_FREEZE: assert property (hold_req ##1 hold_req |-> $stable(pad_out) && $stable(pad_oe_n))
        else $error("pads moved during hold");
    AST_DATA_DRIVE: assert property (p0_strong && source_ff[0][1:0] == SRC_DATA_REG |=>
        !pad_oe_n[0] && pad_out[0] == $past(data_out_ff[0][0]))
        else $error("data-out not driven");
    AST_FIXED_ROUTE: assert property (p0_strong && source_ff[0][1:0] == SRC_FIXED |=>
        pad_out[0] == $past(fixed_fn_out[0]))
        else $error("fixed function not routed");
    AST_SYNC_DELAY: assert property ($past(in_gate[0]) |-> pin_state_ff[0][0] == $past(pad_in[0], 3))
        else $error("pin state not three cycles behind pad");
    AST_STATUS_SET: assert property (pin_event[0] && mask_ff[0][0] |=> status_ff[0][0])
        else $error("event lost");
    AST_PORT_REQ: assert property ((status_ff[0] & mask_ff[0]) != 8'h00 |=> port_irq[0] && irq)
        else $error("port request missing");
    AST_SLOW_SLEW: assert property (!hold_req && config_ff[0][CFG_SLOW_LSB] |=> pad_slow[0])
        else $error("slew select ignored");
    AST_LVTTL_SEL: assert property (!hold_req ##1 !hold_req |-> pad_lvttl[0] == $past(config_ff[0][CFG_LVTTL_LSB]))
        else $error("threshold select ignored");

    COV_EVENT_IRQ: cover property (pin_event[0] && mask_ff[0][0] ##2 port_irq[0]);
    COV_HOLD_RUN: cover property (hold_req [*4]);
    COV_W1C: cover property (status_ff[0][0] ##1 wr_take && acc_ofs == OFS_INT_STATUS ##1 !status_ff[0][0]);
endmodule // gpc_port_ctrl
`default_nettype wire

/* File: rtl/gpc_sync.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// two-stage level synchroniser bank
// ****************************************
module gpc_sync
#(
    parameter int WIDTH = 8
)
(
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] stable_ff;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_ff   <= '0;
            stable_ff <= '0;
        end
        else
        begin
            meta_ff   <= async_in;
            stable_ff <= meta_ff;
        end
    end

    assign sync_out = stable_ff;
endmodule // gpc_sync
`default_nettype wire

/* File: tb/gpc_pin_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// outside world at the pads
// ****************************************
module gpc_pin_model
    import gpc_pkg::*;
(
    input  wire logic [NUM_PINS-1:0] pad_out,
    input  wire logic [NUM_PINS-1:0] pad_oe_n,
    input  wire logic [NUM_PINS-1:0] pad_pull_up,
    input  wire logic [NUM_PINS-1:0] pad_pull_down,
    input  wire logic [NUM_PINS-1:0] ext_val,
    output logic      [NUM_PINS-1:0] pad_in
);
    // chip drive wins, then a pull, else the external source decides
    assign pad_in = (~pad_oe_n & pad_out)
                  | (pad_oe_n & (pad_pull_up | (~pad_pull_down & ext_val)));
endmodule // gpc_pin_model
`default_nettype wire

/* File: tb/gpio_port_pin_control_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module gpio_port_pin_control_tb
    import gpc_pkg::*;
;
    // per drive mode, data out high: oe_n, up, down, weak
    localparam logic [8:0] OEN_TBL = 9'h155;
    localparam logic [8:0] UP_TBL  = 9'h014;
    localparam logic [8:0] DN_TBL  = 9'h028;
    localparam logic [8:0] WK_TBL  = 9'h030;

    logic                 clk = 1'b0, reset_n = 1'b0, hold_req = 1'b0;
    logic                 psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0]    paddr = '0;
    logic [31:0]          pwdata = '0, prdata, rdat;
    logic                 pready, pslverr, rerr, irq;
    logic [NUM_PINS-1:0]  pad_in, pad_out, pad_oe_n, pad_pull_up, pad_pull_down, pad_weak;
    logic [NUM_PINS-1:0]  pad_in_en, pad_lvttl, pad_slow, pin_to_fabric, ext_val = '0;
    logic [NUM_PINS-1:0]  fixed_fn_out = {NUM_PORTS{8'h96}}, fabric_out = {NUM_PORTS{8'h69}};
    logic [NUM_PORTS-1:0] port_irq;
    int                   err_count = 0, n_compared = 0;

    always #12.5 clk = ~clk;

    gpc_port_ctrl i_gpc_port_ctrl (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .pad_in, .pad_out, .pad_oe_n, .pad_pull_up, .pad_pull_down,
        .pad_weak, .pad_in_en, .pad_lvttl, .pad_slow, .fixed_fn_out, .fabric_out, .pin_to_fabric,
        .hold_req, .port_irq, .irq);

    gpc_pin_model i_gpc_pin_model (.pad_out, .pad_oe_n, .pad_pull_up, .pad_pull_down, .ext_val, .pad_in);

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic results();
        $display("errors %0d compared %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic fail_out(input string m);
        err_count++;
        $display("[FAIL] %0t %s", $time, m);
        results();
    endtask

    // one apb transfer; waits on pready, never on a fixed count
    task automatic apb(input logic wr, input int p, input logic [5:0] o, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= 12'(p * 64) + 12'(o);
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // look at pready while it stands, then take the answer at the next rising edge
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
            fail_out("apb timeout");
        @(posedge clk);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input int p, input logic [5:0] o, input logic [31:0] e);
        apb(1'b0, p, o, 32'h0);
        chk(rdat, e, "read data");
        chk({31'h0, rerr}, 32'h0, "read error");
    endtask

    task automatic wait_irq(input int p, input logic lvl);
        int n;
        n = 0;
        while (port_irq[p] !== lvl && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        if (port_irq[p] !== lvl)
            fail_out("irq wait timeout");
        chk({31'h0, irq}, {31'h0, lvl}, "summary irq");
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        chk({31'h0, &pad_oe_n}, 32'h1, "all pins released");
        chk({31'h0, |pad_in_en}, 32'h0, "inputs off");
        chk({19'h0, port_irq}, 32'h0, "irq idle");
        rdc(12, OFS_DRIVE_MODE, 32'h0);
        rdc(0, OFS_PIN_CONFIG, 32'h0);
        rdc(0, OFS_INT_MASK, 32'h0);
        apb(1'b0, 13, OFS_DATA_OUT, 32'h0);
        chk({31'h0, rerr}, 32'h1, "unmapped error");
        chk(rdat, 32'h0, "unmapped data");
    endtask

    task automatic t_modes();
        apb(1'b1, 3, OFS_DATA_OUT, 32'ha5);
        // every drive mode on pin 0 of port 3
        for (int m = 0; m < 9; m++)
        begin
            apb(1'b1, 3, OFS_DRIVE_MODE, 32'(m));
            repeat (2) @(posedge clk);
            chk({pad_oe_n[24], pad_pull_up[24], pad_pull_down[24], pad_weak[24], pad_in_en[24]},
                {OEN_TBL[m], UP_TBL[m], DN_TBL[m], WK_TBL[m], m != 0}, "drive mode");
        end
        apb(1'b1, 3, OFS_DRIVE_MODE, 32'h1111_1111);
        repeat (8) @(posedge clk);
        chk(32'(pad_out[31:24]), 32'ha5, "pad value");
        apb(1'b1, 3, OFS_PIN_STATE, 32'h0);
        rdc(3, OFS_PIN_STATE, 32'ha5);
        apb(1'b1, 3, OFS_DATA_OUT, 32'h5a);
        repeat (2) @(posedge clk);
        chk(32'(pin_to_fabric[31:24]), 32'ha5, "not yet synchronised");
        repeat (4) @(posedge clk);
        chk(32'(pin_to_fabric[31:24]), 32'h5a, "synchronised");
    endtask

    task automatic t_cfg();
        apb(1'b1, 5, OFS_DRIVE_MODE, 32'h1111_1111);
        apb(1'b1, 5, OFS_PIN_CONFIG, 32'h0102_0408);
        repeat (2) @(posedge clk);
        chk(32'(pad_lvttl[47:40]), 32'h08, "threshold");
        chk(32'(pad_slow[47:40]), 32'h01, "slew");
        chk(32'(pad_oe_n[47:40]), 32'h02, "output disable");
        chk(32'(pad_in_en[47:40]), 32'hfb, "input disable");
        rdc(5, OFS_PIN_CONFIG, 32'h0102_0408);
        // pin 0 of port 0 is the pin that the design's assertions watch
        apb(1'b1, 0, OFS_DRIVE_MODE, 32'h1);
        apb(1'b1, 0, OFS_PIN_CONFIG, 32'h0101_0101);
        repeat (2) @(posedge clk);
        chk({pad_oe_n[0], pad_in_en[0], pad_slow[0], pad_lvttl[0]}, 32'hb, "pin 0 config");
        apb(1'b1, 0, OFS_INT_MASK, 32'h01);
        apb(1'b1, 0, OFS_PIN_CONFIG, 32'h0);
        apb(1'b1, 0, OFS_DATA_OUT, 32'h01);
        wait_irq(0, 1'b1);
        rdc(0, OFS_INT_STATUS, 32'h01);
        apb(1'b1, 0, OFS_INT_STATUS, 32'h01);
        wait_irq(0, 1'b0);
        apb(1'b1, 0, OFS_INT_MASK, 32'h0);
        apb(1'b1, 0, OFS_SOURCE_SEL, 32'h1);
        repeat (2) @(posedge clk);
        chk(32'(pad_out[0]), 32'h0, "pin 0 fixed source");
    endtask

    task automatic t_irq();
        apb(1'b1, 7, OFS_DRIVE_MODE, 32'h8888_8888);
        apb(1'b1, 7, OFS_INT_MASK, 32'h01);
        repeat (6) @(posedge clk);
        ext_val[57] <= 1'b1;
        repeat (8) @(posedge clk);
        chk({31'h0, port_irq[7]}, 32'h0, "masked pin quiet");
        rdc(7, OFS_INT_STATUS, 32'h0);
        ext_val[56] <= 1'b1;
        wait_irq(7, 1'b1);
        rdc(7, OFS_PIN_STATE, 32'h03);
        rdc(7, OFS_INT_STATUS, 32'h01);
        rdc(7, OFS_INT_STATUS, 32'h01);
        apb(1'b1, 7, OFS_INT_STATUS, 32'h01);
        wait_irq(7, 1'b0);
        rdc(7, OFS_INT_STATUS, 32'h0);
    endtask

    // hold freezes the pad while the register moves on
    task automatic t_hold();
        @(posedge clk);
        hold_req <= 1'b1;
        apb(1'b1, 3, OFS_DATA_OUT, 32'h3c);
        repeat (3) @(posedge clk);
        chk(32'(pad_out[31:24]), 32'h5a, "held");
        hold_req <= 1'b0;
        repeat (3) @(posedge clk);
        chk(32'(pad_out[31:24]), 32'h3c, "released");
    endtask

    task automatic t_src();
        apb(1'b1, 3, OFS_SOURCE_SEL, 32'h5555);
        repeat (2) @(posedge clk);
        chk(32'(pad_out[31:24]), 32'h96, "fixed source");
        apb(1'b1, 3, OFS_SOURCE_SEL, 32'haaaa);
        repeat (2) @(posedge clk);
        chk(32'(pad_out[31:24]), 32'h69, "fabric source");
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_modes();
        t_cfg();
        t_irq();
        t_hold();
        t_src();
        results();
    end
endmodule // gpio_port_pin_control_tb
`default_nettype wire
